//--- include/vqbx_defs.vh
// Offsets, field positions and reset values of the virtqueue exchange engine
`ifndef VQBX_DEFS_VH
`define VQBX_DEFS_VH

// ********************************
// Register offsets
// ********************************
`define VQBX_OFF_CTRL       8'h00
`define VQBX_OFF_STATUS     8'h04
`define VQBX_OFF_QSIZE      8'h08
`define VQBX_OFF_DESC_LO    8'h0c
`define VQBX_OFF_DESC_HI    8'h10
`define VQBX_OFF_AVAIL_LO   8'h14
`define VQBX_OFF_AVAIL_HI   8'h18
`define VQBX_OFF_USED_LO    8'h1c
`define VQBX_OFF_USED_HI    8'h20
`define VQBX_OFF_NOTIFY     8'h24
`define VQBX_OFF_INDEX      8'h28
`define VQBX_OFF_CHAIN      8'h2c
`define VQBX_OFF_ELEM_SEL   8'h30
`define VQBX_OFF_ELEM_ALO   8'h34
`define VQBX_OFF_ELEM_AHI   8'h38
`define VQBX_OFF_ELEM_LEN   8'h3c
`define VQBX_OFF_ELEM_FLG   8'h40
`define VQBX_OFF_DONE       8'h44

// ********************************
// Control and status bits
// ********************************
`define VQBX_CTRL_DRV_READY 0
`define VQBX_CTRL_SUPPRESS  1
`define VQBX_CTRL_CFG_CHG   2
`define VQBX_CTRL_NEED_RST  3
`define VQBX_CTRL_DEV_RST   4
`define VQBX_ST_LIVE        0
`define VQBX_ST_BUSY        1
`define VQBX_ST_NEED_RST    2
`define VQBX_ST_ERROR       3
`define VQBX_ST_CHAIN       4
`define VQBX_ST_QSIZE_OK    5

// ********************************
// Ring layout
// ********************************
`define VQBX_DESC_F_NEXT    0
`define VQBX_DESC_F_WRITE   1
`define VQBX_AVAIL_F_NO_INT 0
`define VQBX_DESC_SHIFT     4
`define VQBX_RING_OFF       64'h0000_0000_0000_0004
`define VQBX_QSIZE_MAX      16'h8000
`define VQBX_QSIZE_RST      16'h0100
`define VQBX_FLAGS_BE       4'h3

`endif

//--- hw/vqbx_elem_mem.v
// Small memory of fetched chain elements with registered read data
`default_nettype none

module vqbx_elem_mem #(
    parameter WIDTH = 112,
    parameter AW    = 4
) (
    input  wire             sys_clk,
    input  wire             wr_en,
    input  wire [AW-1:0]    wr_addr,
    input  wire [WIDTH-1:0] wr_data,
    input  wire [AW-1:0]    rd_addr,
    output reg  [WIDTH-1:0] rd_data_q
);

    reg [WIDTH-1:0] mem [0:(1<<AW)-1];

    // ********************************
    // Storage
    // ********************************
    always @(posedge sys_clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_q <= mem[rd_addr];
    end

endmodule

`default_nettype wire

//--- hw/vqbx_engine.v
// Device-side virtqueue engine: ring polling, chain fetch and APB registers
// Operation
// - Queue size power of two, at most 32768
// - Ring index wraps modulo 65536
// - Slots beyond published index stay invisible
// - Device fetches chains after a notify, or polls index while suppressing
// - Device may suppress notifications via used flags
// - Interrupt after chain use, unless driver suppresses
// - Configuration change raises configuration interrupt
// - Needs-reset status also raises configuration interrupt
// - Driver-ready makes queue live; reset clears
// - Spurious notifications are harmless
`default_nettype none
`include "vqbx_defs.vh"

module vqbx_engine #(
    parameter ELEM_AW = 4
) (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         mem_req,
    output reg         mem_we,
    output reg  [63:0] mem_addr,
    output reg  [3:0]  mem_be,
    output reg  [31:0] mem_wdata,
    input  wire        mem_ack,
    input  wire [31:0] mem_rdata,
    output reg         used_irq,
    output reg         config_irq,
    output reg         queue_live
);

    // ********************************
    // States
    // ********************************
    localparam ST_IDLE  = 3'd0;
    localparam ST_IDX   = 3'd1;
    localparam ST_SLOT  = 3'd2;
    localparam ST_DESC  = 3'd3;
    localparam ST_HOLD  = 3'd4;
    localparam ST_FLAGS = 3'd5;

    reg  [2:0]         st_q;
    reg  [1:0]         w_q;
    reg                supp_q;
    reg                supp_pub_q;
    reg  [15:0]        qsize_q;
    reg  [63:0]        desc_base_q;
    reg  [63:0]        avail_base_q;
    reg  [63:0]        used_base_q;
    reg                notify_q;
    reg                nreset_q;
    reg                err_q;
    reg                drst_q;
    reg  [15:0]        last_q;
    reg  [15:0]        pub_q;
    reg                noint_q;
    reg  [15:0]        head_q;
    reg  [15:0]        cur_q;
    reg  [ELEM_AW:0]   cnt_q;
    reg                chain_q;
    reg  [63:0]        e_addr_q;
    reg  [31:0]        e_len_q;
    reg  [ELEM_AW-1:0] sel_q;

    wire               acc       = psel & penable & pready;
    wire               wr        = acc & pwrite;
    wire               ctrl_wr   = wr & (paddr == `VQBX_OFF_CTRL);
    wire               notify_wr = wr & (paddr == `VQBX_OFF_NOTIFY);
    wire               done_wr   = wr & (paddr == `VQBX_OFF_DONE) & chain_q;
    wire [15:0]        qmask     = qsize_q - 16'h0001;
    wire               qsize_ok  = (qsize_q != 16'h0000) && ((qsize_q & qmask) == 16'h0000)
                                   && (qsize_q <= `VQBX_QSIZE_MAX);
    wire [15:0]        pending   = pub_q - last_q;
    wire [15:0]        slot      = last_q & qmask;
    wire [63:0]        slot_addr = avail_base_q + `VQBX_RING_OFF
                                   + {47'h0, slot, 1'b0};
    wire [63:0]        desc_next = desc_base_q
                                   + {44'h0, mem_rdata[31:16] & qmask, 4'h0};
    wire [15:0]        slot_val  = slot_addr[1] ? mem_rdata[31:16] : mem_rdata[15:0];
    wire               elem_we   = (st_q == ST_DESC) && mem_ack && (w_q == 2'd3);
    wire [111:0]       elem_wd   = {mem_rdata[15:0], e_len_q, e_addr_q};
    wire [111:0]       elem_rd;
    wire               cfg_evt;
    wire               nr_set;
    wire               loop_err;
    reg  [31:0]        rd_mux;
    reg                rd_hit;

    assign nr_set   = (ctrl_wr & pwdata[`VQBX_CTRL_NEED_RST]) | loop_err;
    assign cfg_evt  = (ctrl_wr & pwdata[`VQBX_CTRL_CFG_CHG])
                      | (nr_set & ~nreset_q);
    assign loop_err = elem_we & mem_rdata[`VQBX_DESC_F_NEXT]
                      & (cnt_q == {1'b0, {ELEM_AW{1'b1}}});

    vqbx_elem_mem #(
        .WIDTH (112),
        .AW    (ELEM_AW)
    ) u_elem (
        .sys_clk   (sys_clk),
        .wr_en     (elem_we),
        .wr_addr   (cnt_q[ELEM_AW-1:0]),
        .wr_data   (elem_wd),
        .rd_addr   (sel_q),
        .rd_data_q (elem_rd)
    );

    // ********************************
    // Register read mux
    // ********************************
    always @*
    begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr)
            `VQBX_OFF_CTRL:     rd_mux = {30'h0, supp_q, queue_live};
            `VQBX_OFF_STATUS:   rd_mux = {26'h0, qsize_ok, chain_q, err_q, nreset_q,
                                          (st_q != ST_IDLE), queue_live};
            `VQBX_OFF_QSIZE:    rd_mux = {16'h0, qsize_q};
            `VQBX_OFF_DESC_LO:  rd_mux = desc_base_q[31:0];
            `VQBX_OFF_DESC_HI:  rd_mux = desc_base_q[63:32];
            `VQBX_OFF_AVAIL_LO: rd_mux = avail_base_q[31:0];
            `VQBX_OFF_AVAIL_HI: rd_mux = avail_base_q[63:32];
            `VQBX_OFF_USED_LO:  rd_mux = used_base_q[31:0];
            `VQBX_OFF_USED_HI:  rd_mux = used_base_q[63:32];
            `VQBX_OFF_NOTIFY:   rd_mux = 32'h0000_0000;
            `VQBX_OFF_INDEX:    rd_mux = {pub_q, last_q};
            `VQBX_OFF_CHAIN:    rd_mux = {{(15-ELEM_AW){1'b0}}, cnt_q, head_q};
            `VQBX_OFF_ELEM_SEL: rd_mux = {{(32-ELEM_AW){1'b0}}, sel_q};
            `VQBX_OFF_ELEM_ALO: rd_mux = elem_rd[31:0];
            `VQBX_OFF_ELEM_AHI: rd_mux = elem_rd[63:32];
            `VQBX_OFF_ELEM_LEN: rd_mux = elem_rd[95:64];
            `VQBX_OFF_ELEM_FLG: rd_mux = {16'h0, elem_rd[111:96]};
            `VQBX_OFF_DONE:     rd_mux = 32'h0000_0000;
            default:            rd_hit = 1'b0;
        endcase
    end

    // ********************************
    // APB slave and configuration
    // ********************************
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            prdata       <= 32'h0000_0000;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            supp_q       <= 1'b0;
            qsize_q      <= `VQBX_QSIZE_RST;
            desc_base_q  <= 64'h0;
            avail_base_q <= 64'h0;
            used_base_q  <= 64'h0;
            sel_q        <= {ELEM_AW{1'b0}};
            config_irq   <= 1'b0;
        end
        else
        begin
            pready     <= psel & penable & ~pready;
            pslverr    <= psel & penable & ~pready & ~rd_hit;
            prdata     <= (psel & penable & ~pready & ~pwrite) ? rd_mux : 32'h0000_0000;
            config_irq <= cfg_evt;
            if (ctrl_wr)
            begin
                supp_q <= pwdata[`VQBX_CTRL_SUPPRESS];
            end
            if (wr)
            begin
                case (paddr)
                    `VQBX_OFF_QSIZE:    qsize_q            <= pwdata[15:0];
                    `VQBX_OFF_DESC_LO:  desc_base_q[31:0]  <= pwdata;
                    `VQBX_OFF_DESC_HI:  desc_base_q[63:32] <= pwdata;
                    `VQBX_OFF_AVAIL_LO: avail_base_q[31:0] <= pwdata;
                    `VQBX_OFF_AVAIL_HI: avail_base_q[63:32] <= pwdata;
                    `VQBX_OFF_USED_LO:  used_base_q[31:0]  <= pwdata;
                    `VQBX_OFF_USED_HI:  used_base_q[63:32] <= pwdata;
                    `VQBX_OFF_ELEM_SEL: sel_q              <= pwdata[ELEM_AW-1:0];
                    default:            sel_q              <= sel_q;
                endcase
            end
        end
    end

    // ********************************
    // Ring engine
    // ********************************
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q       <= ST_IDLE;
            w_q        <= 2'd0;
            queue_live <= 1'b0;
            supp_pub_q <= 1'b0;
            notify_q   <= 1'b0;
            nreset_q   <= 1'b0;
            err_q      <= 1'b0;
            drst_q     <= 1'b0;
            last_q     <= 16'h0;
            pub_q      <= 16'h0;
            noint_q    <= 1'b0;
            head_q     <= 16'h0;
            cur_q      <= 16'h0;
            cnt_q      <= {(ELEM_AW+1){1'b0}};
            chain_q    <= 1'b0;
            e_addr_q   <= 64'h0;
            e_len_q    <= 32'h0;
            mem_req    <= 1'b0;
            mem_we     <= 1'b0;
            mem_addr   <= 64'h0;
            mem_be     <= 4'h0;
            mem_wdata  <= 32'h0;
            used_irq   <= 1'b0;
        end
        else
        begin
            used_irq <= 1'b0;
            if (ctrl_wr & pwdata[`VQBX_CTRL_DRV_READY] & ~drst_q)
            begin
                queue_live <= 1'b1;
            end
            if (ctrl_wr & pwdata[`VQBX_CTRL_DEV_RST])
            begin
                drst_q <= 1'b1;
            end
            if (nr_set)
            begin
                nreset_q <= 1'b1;
            end
            if (notify_wr)
            begin
                notify_q <= 1'b1;
            end
            if (done_wr)
            begin
                chain_q  <= 1'b0;
                used_irq <= ~noint_q;
            end
            case (st_q)
                ST_IDLE:
                begin
                    if (drst_q)
                    begin
                        queue_live <= 1'b0;
                        drst_q     <= 1'b0;
                        notify_q   <= notify_wr;
                        nreset_q   <= nr_set;
                        err_q      <= 1'b0;
                        last_q     <= 16'h0;
                        pub_q      <= 16'h0;
                        chain_q    <= 1'b0;
                        supp_pub_q <= 1'b0;
                    end
                    else if (queue_live && (supp_q != supp_pub_q))
                    begin
                        st_q      <= ST_FLAGS;
                        mem_req   <= 1'b1;
                        mem_we    <= 1'b1;
                        mem_be    <= `VQBX_FLAGS_BE;
                        mem_addr  <= used_base_q;
                        mem_wdata <= {31'h0, supp_q};
                    end
                    else if (queue_live && qsize_ok && !err_q && !chain_q
                             && (notify_q || supp_q || (pending != 16'h0)))
                    begin
                        st_q     <= ST_IDX;
                        notify_q <= notify_wr;
                        mem_req  <= 1'b1;
                        mem_we   <= 1'b0;
                        mem_be   <= 4'hf;
                        mem_addr <= avail_base_q;
                    end
                end
                ST_FLAGS:
                begin
                    if (mem_ack)
                    begin
                        mem_req    <= 1'b0;
                        mem_we     <= 1'b0;
                        supp_pub_q <= mem_wdata[0];
                        st_q       <= ST_IDLE;
                    end
                end
                ST_IDX:
                begin
                    if (mem_ack)
                    begin
                        pub_q   <= mem_rdata[31:16];
                        noint_q <= mem_rdata[`VQBX_AVAIL_F_NO_INT];
                        if (mem_rdata[31:16] != last_q)
                        begin
                            st_q     <= ST_SLOT;
                            mem_addr <= {slot_addr[63:2], 2'b00};
                        end
                        else
                        begin
                            mem_req <= 1'b0;
                            st_q    <= ST_IDLE;
                        end
                    end
                end
                ST_SLOT:
                begin
                    if (mem_ack)
                    begin
                        head_q   <= slot_val;
                        cur_q    <= slot_val & qmask;
                        cnt_q    <= {(ELEM_AW+1){1'b0}};
                        w_q      <= 2'd0;
                        mem_addr <= desc_base_q + {44'h0, slot_val & qmask, 4'h0};
                        st_q     <= ST_DESC;
                    end
                end
                ST_DESC:
                begin
                    if (mem_ack)
                    begin
                        w_q <= w_q + 2'd1;
                        case (w_q)
                            2'd0:    e_addr_q[31:0]  <= mem_rdata;
                            2'd1:    e_addr_q[63:32] <= mem_rdata;
                            2'd2:    e_len_q         <= mem_rdata;
                            default: e_len_q         <= e_len_q;
                        endcase
                        if (w_q != 2'd3)
                        begin
                            mem_addr <= mem_addr + 64'h4;
                        end
                        else if (loop_err)
                        begin
                            err_q   <= 1'b1;
                            mem_req <= 1'b0;
                            st_q    <= ST_IDLE;
                        end
                        else if (mem_rdata[`VQBX_DESC_F_NEXT])
                        begin
                            cnt_q    <= cnt_q + 1'b1;
                            cur_q    <= mem_rdata[31:16] & qmask;
                            mem_addr <= desc_next;
                        end
                        else
                        begin
                            cnt_q   <= cnt_q + 1'b1;
                            last_q  <= last_q + 16'h1;
                            chain_q <= 1'b1;
                            mem_req <= 1'b0;
                            st_q    <= ST_HOLD;
                        end
                    end
                end
                ST_HOLD:
                begin
                    st_q <= ST_IDLE;
                end
                default:
                begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

//--- verif/vqbx_chk_sva.sv
// Concurrent checks on the virtqueue engine ports
`default_nettype none
`include "vqbx_defs.vh"

module vqbx_chk (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [63:0] mem_addr,
    input wire logic [3:0]  mem_be,
    input wire logic        mem_ack,
    input wire logic        used_irq,
    input wire logic        config_irq,
    input wire logic        queue_live
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********************************
    // Properties
    // ********************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_wr(logic [7:0] a);
        psel && penable && pready && pwrite && paddr == a;
    endsequence
    sequence s_ctrl;
        s_wr(`VQBX_OFF_CTRL);
    endsequence
    req_when_live_a: assert property (mem_req |-> queue_live)
        else $error("memory request on a queue that is not live");
    live_set_a: assert property (s_ctrl ##0 pwdata[0] |-> ##[1:2] queue_live)
        else $error("driver ready did not make the queue live");
    reset_drop_a: assert property (s_ctrl ##0 pwdata[4] |-> ##[1:40] !queue_live)
        else $error("device reset left the queue live");
    used_cause_a: assert property (used_irq |-> $past(psel && penable && pready && pwrite
        && paddr == `VQBX_OFF_DONE))
        else $error("used interrupt without a finished chain");
    used_pulse_a: assert property (used_irq |=> !used_irq)
        else $error("used interrupt longer than one cycle");
    cfg_raise_a: assert property (s_ctrl ##0 pwdata[2] |-> ##[1:2] config_irq)
        else $error("configuration change raised no interrupt");
    cfg_pulse_a: assert property (config_irq |=> !config_irq)
        else $error("configuration interrupt longer than one cycle");
    flag_write_a: assert property (mem_req && mem_we |-> mem_be == 4'h3)
        else $error("used flags write with wrong byte enables");
    req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("memory request changed before acknowledge");
    read_word_a: assert property (mem_req && !mem_we |-> mem_be == 4'hf
        && mem_addr[1:0] == 2'h0)
        else $error("ring read not a whole aligned word");
endmodule

bind vqbx_engine vqbx_chk u_chk (.sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_be(mem_be), .mem_ack(mem_ack),
    .used_irq(used_irq), .config_irq(config_irq), .queue_live(queue_live));
`default_nettype wire

//--- verif/vqbx_mem_model.sv
// Shared memory holding the driver's rings, with adjustable answer delay
`default_nettype none

module vqbx_mem_model (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [63:0] mem_addr,
    input wire logic [3:0]  mem_be,
    input wire logic [31:0] mem_wdata,
    output var logic        mem_ack,
    output var logic [31:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:255] = '{default: 32'h0};
    int          lat = 0;
    int          cnt;
    // ********************************
    // Answer after lat wait cycles
    // ********************************
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            mem_ack <= 1'b0;
            mem_rdata <= 32'h0;
            cnt <= 0;
        end
        else
        begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack && cnt < lat)
                cnt <= cnt + 1;
            else if (mem_req && !mem_ack)
            begin
                cnt <= 0;
                mem_ack <= 1'b1;
                mem_rdata <= mem[mem_addr[9:2]];
                for (int b = 0; b < 4; b++)
                    if (mem_we && mem_be[b])
                        mem[mem_addr[9:2]][8*b+:8] <= mem_wdata[8*b+:8];
            end
        end
    end
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench of the virtqueue engine over APB and shared memory
`default_nettype none
`include "vqbx_defs.vh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic [7:0]  paddr   = 8'h00;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata, mem_wdata, mem_rdata, rd;
    logic [63:0] mem_addr;
    logic [3:0]  mem_be;
    logic        pready, pslverr, mem_req, mem_we, mem_ack, used_irq, config_irq, queue_live;
    logic        err;
    logic [31:0] qs [3] = '{32'h3, 32'h8000, 32'h4};
    int          errors = 0, samples_checked = 0, cycles = 0, n_used = 0, n_cfg = 0;
    always #5 sys_clk = ~sys_clk;
    vqbx_engine u_dut (.sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .used_irq(used_irq), .config_irq(config_irq),
        .queue_live(queue_live));
    vqbx_mem_model u_mem (.sys_clk(sys_clk), .rst(rst), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    // ********************************
    // Tasks
    // ********************************
    task automatic end_of_test();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic put(input int a, input logic [31:0] d);
        u_mem.mem[a>>2] = d;
    endtask
    task automatic wait_held();
        for (int i = 0; i < 50; i++)
        begin
            apb(1'b0, `VQBX_OFF_STATUS, 32'h0);
            if (rd[`VQBX_ST_CHAIN] === 1'b1)
                break;
        end
    endtask
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        n_used <= n_used + int'(used_irq === 1'b1);
        n_cfg <= n_cfg + int'(config_irq === 1'b1);
        if (cycles == 20000)
        begin
            errors++;
            end_of_test();
        end
    end
    // ********************************
    // Tests
    // ********************************
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rdchk(`VQBX_OFF_QSIZE, 32'h100);
        rdchk(`VQBX_OFF_STATUS, 32'h20);
        apb(1'b0, 8'hfc, 32'h0);
        chk({31'h0, err}, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, `VQBX_OFF_QSIZE, qs[i]);
            rdchk(`VQBX_OFF_STATUS, {26'h0, i > 0, 5'h0});
        end
        apb(1'b1, `VQBX_OFF_AVAIL_LO, 32'h200);
        apb(1'b1, `VQBX_OFF_USED_LO, 32'h300);
        put(32'h00, 32'h1000);
        put(32'h08, 32'h40);
        put(32'h0c, 32'h0001_0001);
        put(32'h10, 32'h2000);
        put(32'h18, 32'h80);
        put(32'h1c, 32'h2);
        put(32'h2c, 32'h0);
        put(32'h3c, 32'h2);
        put(32'h204, 32'h0002_0000);
        put(32'h208, 32'h3);
        apb(1'b1, `VQBX_OFF_NOTIFY, 32'h0);
        apb(1'b1, `VQBX_OFF_CTRL, 32'h1);
        repeat (5) @(posedge sys_clk);
        rdchk(`VQBX_OFF_STATUS, 32'h21);
        apb(1'b1, `VQBX_OFF_NOTIFY, 32'h0);
        repeat (20) @(posedge sys_clk);
        rdchk(`VQBX_OFF_INDEX, 32'h0);
        rdchk(`VQBX_OFF_STATUS, 32'h21);
        u_mem.lat = 3;
        put(32'h200, 32'h0001_0000);
        apb(1'b1, `VQBX_OFF_NOTIFY, 32'h0);
        wait_held();
        rdchk(`VQBX_OFF_CHAIN, 32'h0002_0000);
        rdchk(`VQBX_OFF_INDEX, 32'h0001_0001);
        apb(1'b1, `VQBX_OFF_ELEM_SEL, 32'h1);
        rdchk(`VQBX_OFF_ELEM_ALO, 32'h2000);
        rdchk(`VQBX_OFF_ELEM_LEN, 32'h80);
        rdchk(`VQBX_OFF_ELEM_FLG, 32'h2);
        apb(1'b1, `VQBX_OFF_DONE, 32'h0);
        repeat (2) @(posedge sys_clk);
        chk(32'(n_used), 32'h1);
        u_mem.lat = 0;
        put(32'h200, 32'h0003_0001);
        apb(1'b1, `VQBX_OFF_NOTIFY, 32'h0);
        wait_held();
        rdchk(`VQBX_OFF_CHAIN, 32'h0001_0002);
        apb(1'b1, `VQBX_OFF_DONE, 32'h0);
        wait_held();
        rdchk(`VQBX_OFF_CHAIN, 32'h0001_0003);
        rdchk(`VQBX_OFF_INDEX, 32'h0003_0003);
        apb(1'b1, `VQBX_OFF_DONE, 32'h0);
        repeat (2) @(posedge sys_clk);
        chk(32'(n_used), 32'h1);
        apb(1'b1, `VQBX_OFF_CTRL, 32'h3);
        repeat (20) @(posedge sys_clk);
        chk(u_mem.mem[192], 32'h1);
        apb(1'b1, `VQBX_OFF_CTRL, 32'h5);
        apb(1'b1, `VQBX_OFF_CTRL, 32'h9);
        apb(1'b0, `VQBX_OFF_STATUS, 32'h0);
        chk(rd & 32'h5, 32'h5);
        chk(32'(n_cfg), 32'h2);
        apb(1'b1, `VQBX_OFF_CTRL, 32'h10);
        repeat (20) @(posedge sys_clk);
        rdchk(`VQBX_OFF_INDEX, 32'h0);
        apb(1'b0, `VQBX_OFF_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
